// ---- plcm_pkg.sv ----
//Contract
//- A word move copies the 16-bit source value into the destination.
//- Word, parameter or immediate kinds per operand; immediate source only.
//- A double-word move uses two locations, low half at n, high half at n+1.
//- A signed immediate moved into a parameter is stored two's complement.
//- A 32-bit signed immediate fills parameter n and n+1 when moved there.
//- Parameter operand n addresses servo parameter n directly.
//- The bit area overlays the word store, bit 16n+k being bit k of word n; the code has no bit area, only word access.
//- Word 27: fast timer sig/en/rst/dir, fast counter rst/en/dir/capture.
//- Word 28 bits 0 to 3 are the counting inputs of slow timers 1 to 4.
//- Word 29: fast outputs in bits 0 to 3, then four reset confirmations.
//- Each enabled slow timer advances by one every 0.1 ms.
package plcm_pkg;

    // ************************************************************
    // Register map, word indices (byte address = index * 4)
    // ************************************************************
    localparam logic [9:0] IDX_FAST_CTRL = 10'h01b;
    localparam logic [9:0] IDX_SLOW_IN = 10'h01c;
    localparam logic [9:0] IDX_FAST_STAT = 10'h01d;
    localparam logic [9:0] IDX_STORE_END = 10'h100;
    localparam logic [9:0] IDX_MV_CTRL = 10'h100;
    localparam logic [9:0] IDX_MV_GO = 10'h101;
    localparam logic [9:0] IDX_MV_SRC = 10'h102;
    localparam logic [9:0] IDX_MV_DST = 10'h103;
    localparam logic [9:0] IDX_IMM_LO = 10'h104;
    localparam logic [9:0] IDX_IMM_HI = 10'h105;
    localparam logic [9:0] IDX_MV_STAT = 10'h106;
    localparam logic [9:0] IDX_FAST_CNT = 10'h108;
    localparam logic [9:0] IDX_FAST_CAP = 10'h10c;
    localparam logic [9:0] IDX_SLOW_CNT = 10'h110;

    // ************************************************************
    // Move control fields
    // ************************************************************
    localparam int MV_DBL_BIT = 0;
    localparam int MV_SRC_LSB = 1;
    localparam int MV_DST_LSB = 3;
    localparam logic [1:0] KIND_WORD = 2'h0;
    localparam logic [1:0] KIND_PARAM = 2'h1;
    localparam logic [1:0] KIND_IMM = 2'h2;

    // ************************************************************
    // Word 27 layout
    // ************************************************************
    localparam int FT_STRIDE = 4;
    localparam int FT_SIG = 0;
    localparam int FT_EN = 1;
    localparam int FT_RST = 2;
    localparam int FT_DIR = 3;
    localparam int FC_BASE = 8;
    localparam int FC_RST = 0;
    localparam int FC_EN = 1;
    localparam int FC_DIR = 2;
    localparam int FC_CAP = 3;
    localparam int STAT_CONF_LSB = 4;
    localparam int UNITS = 4;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int SLOW_TICK_NS = 100000;
    localparam int SLOW_TICK_CYC = SLOW_TICK_NS / CLK_PERIOD_NS;
    localparam logic [10:0] SLOW_TICK_LAST = 11'(SLOW_TICK_CYC - 1);

    typedef enum logic [1:0] {
        MV_IDLE = 2'b00,
        MV_FETCH = 2'b01,
        MV_FWAIT = 2'b10,
        MV_STORE = 2'b11
    } plcm_state_t;

endpackage : plcm_pkg

// ---- plcm_mem_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface plcm_mem_if;
    logic en;
    logic we;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport user (output en, output we, output addr, output wdata,
                  input rdata);
    modport store (input en, input we, input addr, input wdata,
                   output rdata);
endinterface : plcm_mem_if
`default_nettype wire

// ---- plcm_word_store.sv ----
`timescale 1ns/1ns
`default_nettype none
module plcm_word_store
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Port
    plcm_mem_if.store m
);
    typedef struct packed {
        logic [255:0][15:0] words;
        logic [15:0] rdata;
    } plcm_store_t;

    plcm_store_t q, d;

    always_comb
    begin
        d = q;
        if (m.en && m.we)
        begin
            d.words[m.addr] = m.wdata;
        end
        else if (m.en)
        begin
            d.rdata = q.words[m.addr];
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign m.rdata = q.rdata;
endmodule : plcm_word_store
`default_nettype wire

// ---- plcm_move_unit.sv ----
`timescale 1ns/1ns
`default_nettype none
module plcm_move_unit
    import plcm_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Servo parameter area
    output logic param_req_o,
    output logic param_we_o,
    output logic [15:0] param_num_o,
    output logic [15:0] param_wdata_o,
    input wire logic param_ack_i,
    input wire logic [15:0] param_rdata_i,
    // Fast counter pins
    input wire logic [1:0] fast_count_pin_i
);
    import plcm_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        plcm_state_t state;
        logic dbl;
        logic [1:0] src_kind;
        logic [1:0] dst_kind;
        logic [15:0] src_op;
        logic [15:0] dst_op;
        logic [31:0] imm;
        logic half;
        logic [1:0][15:0] buf_w;
        logic done;
        logic err;
        logic [15:0] ctl27;
        logic [15:0] ctl27_prev;
        logic [15:0] cnt28;
        logic [UNITS-1:0][15:0] fcnt;
        logic [1:0][15:0] fcap;
        logic [UNITS-1:0] fconf;
        logic [1:0] pin_s1;
        logic [1:0] pin_s2;
        logic [1:0] pin_prev;
        logic [10:0] pre;
        logic [UNITS-1:0][15:0] scnt;
        logic rd_iss;
        logic ack;
        logic [31:0] prdata;
        logic slverr;
    } plcm_regs_t;

    plcm_regs_t q, d;
    plcm_mem_if mem ();

    logic [9:0] idx;
    logic [15:0] stat29;
    logic [UNITS-1:0] outs;
    logic [15:0] src_addr;
    logic [15:0] dst_addr;
    logic [15:0] fetched;
    logic [15:0] rd_word;
    logic last;
    logic evt;
    logic tick;
    logic mv_ctrl_ok;

    plcm_word_store u_store (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .m(mem.user)
    );

    assign idx = paddr_i[11:2];
    assign src_addr = q.src_op + {15'h0000, q.half};
    assign dst_addr = q.dst_op + {15'h0000, q.half};
    assign last = !q.dbl || q.half;
    assign tick = (q.pre == SLOW_TICK_LAST);

    always_comb
    begin
        for (int u = 0; u < UNITS; u++)
        begin
            outs[u] = (q.fcnt[u] != 16'h0000);
        end
    end
    assign stat29 = {8'h00, q.fconf, outs};

    // Word store view with the live control and status words overlaid
    function automatic logic [15:0] overlay(input logic [7:0] a,
                                            input logic [15:0] raw);
        logic [15:0] r;
        r = raw;
        if (a == IDX_FAST_CTRL[7:0])
        begin
            r = q.ctl27;
        end
        else if (a == IDX_SLOW_IN[7:0])
        begin
            r = q.cnt28;
        end
        else if (a == IDX_FAST_STAT[7:0])
        begin
            r = stat29;
        end
        return r;
    endfunction : overlay

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        d = q;
        mem.en = 1'b0;
        mem.we = 1'b0;
        mem.addr = 8'h00;
        mem.wdata = 16'h0000;
        fetched = 16'h0000;
        rd_word = 16'h0000;
        evt = 1'b0;
        mv_ctrl_ok = 1'b0;

        // Pin synchronisers; first stage feeds only the second
        d.pin_s1 = fast_count_pin_i;
        d.pin_s2 = q.pin_s1;
        d.pin_prev = q.pin_s2;
        d.ctl27_prev = q.ctl27;

        // Move sequencer
        unique case (q.state)
            MV_IDLE:
            begin
            end
            MV_FETCH:
            begin
                unique case (q.src_kind)
                    KIND_WORD:
                    begin
                        mem.en = 1'b1;
                        mem.addr = src_addr[7:0];
                        d.state = MV_FWAIT;
                    end
                    KIND_PARAM:
                    begin
                        if (param_ack_i)
                        begin
                            d.buf_w[q.half] = param_rdata_i;
                        end
                    end
                    default:
                    begin
                        d.buf_w[q.half] = q.half ? q.imm[31:16]
                                                 : q.imm[15:0];
                    end
                endcase
                if (q.src_kind != KIND_WORD &&
                    (q.src_kind != KIND_PARAM || param_ack_i))
                begin
                    d.half = !last;
                    d.state = last ? MV_STORE : MV_FETCH;
                end
            end
            MV_FWAIT:
            begin
                fetched = overlay(src_addr[7:0], mem.rdata);
                d.buf_w[q.half] = fetched;
                d.half = !last;
                d.state = last ? MV_STORE : MV_FETCH;
            end
            MV_STORE:
            begin
                if (q.dst_kind == KIND_WORD)
                begin
                    mem.en = 1'b1;
                    mem.we = 1'b1;
                    mem.addr = dst_addr[7:0];
                    mem.wdata = q.buf_w[q.half];
                    if (dst_addr[7:0] == IDX_FAST_CTRL[7:0])
                    begin
                        d.ctl27 = q.buf_w[q.half];
                    end
                    if (dst_addr[7:0] == IDX_SLOW_IN[7:0])
                    begin
                        d.cnt28 = q.buf_w[q.half];
                    end
                end
                if (q.dst_kind == KIND_WORD || param_ack_i)
                begin
                    d.half = !last;
                    d.state = last ? MV_IDLE : MV_STORE;
                    d.done = last;
                end
            end
        endcase

        // APB slave; the store port is free only while the mover idles
        if (psel_i && q.state == MV_IDLE && !q.ack && !q.rd_iss)
        begin
            mem.en = idx < IDX_STORE_END;
            mem.addr = idx[7:0];
            d.rd_iss = 1'b1;
        end
        if (q.rd_iss && psel_i && penable_i)
        begin
            rd_word = overlay(idx[7:0], mem.rdata);
            d.rd_iss = 1'b0;
            d.ack = 1'b1;
            d.slverr = 1'b0;
            d.prdata = 32'h00000000;
            if (idx < IDX_STORE_END)
            begin
                d.prdata = {16'h0000, rd_word};
                d.slverr = pwrite_i && idx == IDX_FAST_STAT;
            end
            else if (idx == IDX_MV_CTRL)
            begin
                d.prdata = {27'h0000000, q.dst_kind, q.src_kind, q.dbl};
            end
            else if (idx == IDX_MV_GO)
            begin
                d.prdata = 32'h00000000;
            end
            else if (idx == IDX_MV_SRC)
            begin
                d.prdata = {16'h0000, q.src_op};
            end
            else if (idx == IDX_MV_DST)
            begin
                d.prdata = {16'h0000, q.dst_op};
            end
            else if (idx == IDX_IMM_LO)
            begin
                d.prdata = {16'h0000, q.imm[15:0]};
            end
            else if (idx == IDX_IMM_HI)
            begin
                d.prdata = {16'h0000, q.imm[31:16]};
            end
            else if (idx == IDX_MV_STAT)
            begin
                d.prdata = {29'h00000000, q.err, q.done,
                            q.state != MV_IDLE};
            end
            else if (idx >= IDX_FAST_CNT && idx < IDX_FAST_CNT + 10'h004)
            begin
                d.prdata = {16'h0000, q.fcnt[idx[1:0]]};
            end
            else if (idx >= IDX_FAST_CAP && idx < IDX_FAST_CAP + 10'h002)
            begin
                d.prdata = {16'h0000, q.fcap[idx[0]]};
            end
            else if (idx >= IDX_SLOW_CNT && idx < IDX_SLOW_CNT + 10'h004)
            begin
                d.prdata = {16'h0000, q.scnt[idx[1:0]]};
            end
            else
            begin
                d.slverr = 1'b1;
            end
        end
        if (q.ack)
        begin
            d.ack = 1'b0;
            if (pwrite_i && !q.slverr)
            begin
                if (idx < IDX_STORE_END)
                begin
                    mem.en = 1'b1;
                    mem.we = 1'b1;
                    mem.addr = idx[7:0];
                    mem.wdata = pwdata_i[15:0];
                    if (idx == IDX_FAST_CTRL)
                    begin
                        d.ctl27 = pwdata_i[15:0];
                    end
                    if (idx == IDX_SLOW_IN)
                    begin
                        d.cnt28 = pwdata_i[15:0];
                    end
                end
                else if (idx == IDX_MV_CTRL)
                begin
                    d.dbl = pwdata_i[MV_DBL_BIT];
                    d.src_kind = pwdata_i[MV_SRC_LSB +: 2];
                    d.dst_kind = pwdata_i[MV_DST_LSB +: 2];
                end
                else if (idx == IDX_MV_SRC)
                begin
                    d.src_op = pwdata_i[15:0];
                end
                else if (idx == IDX_MV_DST)
                begin
                    d.dst_op = pwdata_i[15:0];
                end
                else if (idx == IDX_IMM_LO)
                begin
                    d.imm[15:0] = pwdata_i[15:0];
                end
                else if (idx == IDX_IMM_HI)
                begin
                    d.imm[31:16] = pwdata_i[15:0];
                end
                else if (idx == IDX_MV_GO)
                begin
                    mv_ctrl_ok = q.src_kind != 2'h3 &&
                                 (q.dst_kind == KIND_WORD ||
                                  q.dst_kind == KIND_PARAM);
                    d.err = !mv_ctrl_ok;
                    d.done = !mv_ctrl_ok;
                    d.half = 1'b0;
                    d.state = mv_ctrl_ok ? MV_FETCH : MV_IDLE;
                end
            end
        end

        // ********************************************************
        // Fast timers and counters
        // ********************************************************
        for (int u = 0; u < UNITS; u++)
        begin
            logic en;
            logic rst;
            logic dir;
            int b;
            en = 1'b0;
            rst = 1'b0;
            dir = 1'b0;
            b = 0;
            if (u < 2)
            begin
                b = FT_STRIDE * u;
                en = q.ctl27[b + FT_EN];
                rst = q.ctl27[b + FT_RST];
                dir = q.ctl27[b + FT_DIR];
                evt = q.ctl27[b + FT_SIG] && !q.ctl27_prev[b + FT_SIG];
            end
            else
            begin
                b = FC_BASE + FT_STRIDE * (u - 2);
                en = q.ctl27[b + FC_EN];
                rst = q.ctl27[b + FC_RST];
                dir = q.ctl27[b + FC_DIR];
                evt = q.pin_s2[u - 2] && !q.pin_prev[u - 2];
                if (q.ctl27[b + FC_CAP] && !q.ctl27_prev[b + FC_CAP])
                begin
                    d.fcap[u - 2] = q.fcnt[u];
                end
            end
            if (rst)
            begin
                d.fcnt[u] = 16'h0000;
                d.fconf[u] = (q.fcnt[u] == 16'h0000);
            end
            else
            begin
                d.fconf[u] = 1'b0;
                if (en && evt)
                begin
                    d.fcnt[u] = dir ? q.fcnt[u] - 16'h0001
                                    : q.fcnt[u] + 16'h0001;
                end
            end
        end

        // ********************************************************
        // Slow timers
        // ********************************************************
        d.pre = tick ? 11'h000 : q.pre + 11'h001;
        for (int s = 0; s < UNITS; s++)
        begin
            if (tick && q.cnt28[s])
            begin
                d.scnt[s] = q.scnt[s] + 16'h0001;
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata_o = q.prdata;
    assign pready_o = q.ack;
    assign pslverr_o = q.ack && q.slverr;
    assign param_req_o = (q.state == MV_FETCH && q.src_kind == KIND_PARAM)
                         || (q.state == MV_STORE && q.dst_kind == KIND_PARAM);
    assign param_we_o = (q.state == MV_STORE);
    assign param_num_o = (q.state == MV_STORE) ? dst_addr : src_addr;
    assign param_wdata_o = q.buf_w[q.half];
endmodule : plcm_move_unit
`default_nettype wire

// ---- plcm_move_unit_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module plcm_move_unit_monitor
    import plcm_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Parameter link
    input wire logic param_req_o,
    input wire logic param_we_o,
    input wire logic [15:0] param_num_o,
    input wire logic [15:0] param_wdata_o,
    input wire logic param_ack_i,
    input wire logic [15:0] param_rdata_i,
    input wire logic [1:0] fast_count_pin_i
);
    // ****
    // Checks
    // ****
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    AST_RDY_PULSE: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    AST_RDY_ACCESS: assert property (pready_o |-> psel_i && penable_i)
        else $error("pready outside access phase");
    AST_NO_EARLY: assert property (psel_i && !penable_i |=> !pready_o)
        else $error("pready in first access cycle");
    AST_ERR_RDY: assert property (pslverr_o |-> pready_o)
        else $error("pslverr without pready");
    AST_UNMAPPED: assert property (pready_o && paddr_i[11:2] > 10'h113
        |-> pslverr_o) else $error("unmapped access not refused");
    AST_STAT_RO: assert property (pready_o && pwrite_i
        && paddr_i[11:2] == IDX_FAST_STAT |-> pslverr_o)
        else $error("status write not refused");
    AST_STAT_BITS: assert property (pready_o && !pwrite_i
        && paddr_i[11:2] == IDX_FAST_STAT |-> prdata_o[31:8] == 24'h0)
        else $error("status upper bits set");
    AST_UPPER_ZERO: assert property (pready_o && !pwrite_i
        |-> prdata_o[31:16] == 16'h0) else $error("read upper half set");
    AST_PARAM_HOLD: assert property (param_req_o && !param_ack_i
        |=> param_req_o && $stable(param_num_o) && $stable(param_we_o)
        && $stable(param_wdata_o)) else $error("param request dropped");
    cover property (pready_o && pslverr_o);
    cover property (param_ack_i && param_we_o);
    cover property (param_ack_i && !param_we_o);
endmodule : plcm_move_unit_monitor
bind plcm_move_unit plcm_move_unit_monitor plcm_move_unit_monitor_inst (
    .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .param_req_o(param_req_o),
    .param_we_o(param_we_o), .param_num_o(param_num_o),
    .param_wdata_o(param_wdata_o), .param_ack_i(param_ack_i),
    .param_rdata_i(param_rdata_i), .fast_count_pin_i(fast_count_pin_i));
`default_nettype wire

// ---- plcm_move_unit_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module plcm_move_unit_tb_top;
    import plcm_pkg::*;
    typedef struct packed {logic c; logic r; logic [31:0] m, e;} plcm_note_t;
    logic clock_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
    logic pwrite_i = 1'b0, param_ack_i = 1'b0, pready_o, pslverr_o;
    logic param_req_o, param_we_o;
    logic [11:0] paddr_i = 12'h0;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd, v, w;
    logic [15:0] param_num_o, param_wdata_o, param_rdata_i = 16'h0;
    logic [1:0] fast_count_pin_i = 2'h0;
    logic [15:0] pmem [0:255];
    logic [31:0] pq [$];
    plcm_note_t nq [$];
    plcm_note_t nt;
    int err_total = 0, n_checks = 0, cyc = 0, pw = 0;

    plcm_move_unit plcm_move_unit_inst (.clock_i(clock_i), .rst_i(rst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o),
        .param_req_o(param_req_o), .param_we_o(param_we_o),
        .param_num_o(param_num_o), .param_wdata_o(param_wdata_o),
        .param_ack_i(param_ack_i), .param_rdata_i(param_rdata_i),
        .fast_count_pin_i(fast_count_pin_i));

    initial
    begin
        forever #25 clock_i = ~clock_i;
    end

    // ****
    // Bus and compare tasks
    // ****
    task automatic check(input string nm, input logic [31:0] s, e);
        n_checks++;
        if (s !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, s);
            err_total++;
        end
    endtask : check

    task automatic apb(input logic wr_en, input logic [9:0] ix,
        input logic [31:0] d, input plcm_note_t n);
        int k;
        nq.push_back(n);
        @(posedge clock_i);
        psel_i <= 1'b1;
        pwrite_i <= wr_en;
        paddr_i <= {ix, 2'b00};
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clock_i);
            k++;
        end while (pready_o !== 1'b1 && k < 2000);
        if (pready_o !== 1'b1)
        begin
            err_total++;
        end
        rd = prdata_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic wr(input logic [9:0] ix, input logic [31:0] d);
        apb(1'b1, ix, d, {1'b1, 1'b0, 64'h0});
    endtask : wr

    task automatic rdc(input logic [9:0] ix, input logic [31:0] m, e);
        apb(1'b0, ix, 32'h0, {1'b1, 1'b0, m, e});
    endtask : rdc

    // Poll busy, then judge done and err together
    task automatic mv(input logic db, input logic [1:0] sk, dk,
        input logic [9:0] s, d, input logic [31:0] imm, input logic er);
        int k;
        wr(IDX_MV_CTRL, {27'h0, dk, sk, db});
        wr(IDX_MV_SRC, {22'h0, s});
        wr(IDX_MV_DST, {22'h0, d});
        wr(IDX_IMM_LO, {16'h0, imm[15:0]});
        wr(IDX_IMM_HI, {16'h0, imm[31:16]});
        wr(IDX_MV_GO, 32'h1);
        k = 0;
        do
        begin
            apb(1'b0, IDX_MV_STAT, 32'h0, 66'h0);
            k++;
        end while (rd[0] !== 1'b0 && k < 100);
        rdc(IDX_MV_STAT, 32'h6, er ? 32'h6 : 32'h2);
    endtask : mv

    task automatic end_sim;
        if (err_total == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    // ****
    // Result watchers and parameter side
    // ****
    always @(posedge clock_i)
    begin
        if (psel_i && penable_i && pready_o === 1'b1 && nq.size() > 0)
        begin
            nt = nq.pop_front();
            if (nt.c)
            begin
                check("pslverr", {31'h0, pslverr_o}, {31'h0, nt.r});
                check("prdata", prdata_o & nt.m, nt.e);
            end
        end
    end

    // Random ack delay; idle data line keeps toggling
    always @(posedge clock_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            err_total++;
            end_sim();
        end
    end

    always @(posedge clock_i)
    begin
        if (param_ack_i)
        begin
            param_ack_i <= 1'b0;
            param_rdata_i <= ~param_rdata_i;
            if (param_we_o === 1'b1 && pq.size() > 0)
            begin
                pmem[param_num_o[7:0]] <= param_wdata_o;
                check("param", {param_num_o, param_wdata_o}, pq.pop_front());
            end
        end
        else if (param_req_o === 1'b1 && pw == 0)
        begin
            param_ack_i <= 1'b1;
            param_rdata_i <= pmem[param_num_o[7:0]];
            pw <= $urandom % 3;
        end
        else
        begin
            pw <= (pw > 0) ? pw - 1 : 0;
            param_rdata_i <= ~param_rdata_i;
        end
    end

    // ****
    // Scenarios
    // ****
    initial
    begin
        void'($urandom(32'h70ce));
        pmem[1] = $urandom;
        pmem[2] = $urandom;
        v = $urandom;
        w = $urandom;
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        wr(10, v);
        wr(11, w);
        mv(0, KIND_WORD, KIND_WORD, 10, 2, 0, 0);
        rdc(2, 32'hffff, {16'h0, v[15:0]});
        mv(1, KIND_WORD, KIND_WORD, 10, 4, 0, 0);
        rdc(5, 32'hffff, {16'h0, w[15:0]});
        mv(0, KIND_IMM, KIND_WORD, 0, 6, w, 0);
        rdc(6, 32'hffff, {16'h0, w[15:0]});
        pq.push_back({16'd101, 16'hfffd});
        mv(0, KIND_IMM, KIND_PARAM, 0, 101, 32'hfffffffd, 0);
        pq.push_back({16'd101, 16'hfffd});
        pq.push_back({16'd102, 16'hffff});
        mv(1, KIND_IMM, KIND_PARAM, 0, 101, 32'hfffffffd, 0);
        mv(1, KIND_PARAM, KIND_WORD, 1, 10, 0, 0);
        rdc(10, 32'hffff, {16'h0, pmem[1]});
        rdc(11, 32'hffff, {16'h0, pmem[2]});
        pq.push_back({16'd2, pmem[1]});
        mv(0, KIND_PARAM, KIND_PARAM, 1, 2, 0, 0);
        pq.push_back({16'd101, pmem[1]});
        mv(0, KIND_WORD, KIND_PARAM, 10, 101, 0, 0);
        mv(0, KIND_WORD, KIND_IMM, 10, 3, 0, 1);
        apb(1'b0, 10'h3ff, 32'h0, {1'b1, 1'b1, 64'h0});
        apb(1'b1, IDX_FAST_STAT, 32'hff, {1'b1, 1'b1, 64'h0});
        wr(IDX_FAST_CTRL, 32'h0202);
        rdc(IDX_FAST_CTRL, 32'hffff, 32'h0202);
        repeat (5)
        begin
            wr(IDX_FAST_CTRL, 32'h0203);
            wr(IDX_FAST_CTRL, 32'h0202);
        end
        rdc(IDX_FAST_CNT, 32'hffff, 32'h5);
        wr(IDX_FAST_CTRL, 32'h020b);
        wr(IDX_FAST_CTRL, 32'h020a);
        rdc(IDX_FAST_CNT, 32'hffff, 32'h4);
        repeat (3)
        begin
            fast_count_pin_i <= 2'b01;
            repeat (5) @(posedge clock_i);
            fast_count_pin_i <= 2'b00;
            repeat (5) @(posedge clock_i);
        end
        rdc(IDX_FAST_CNT + 10'h2, 32'hffff, 32'h3);
        wr(IDX_FAST_CTRL, 32'h0a02);
        rdc(IDX_FAST_CAP, 32'hffff, 32'h3);
        rdc(IDX_FAST_STAT, 32'hff, 32'h05);
        wr(IDX_FAST_CTRL, 32'h0104);
        repeat (4) @(posedge clock_i);
        rdc(IDX_FAST_STAT, 32'hff, 32'h50);
        rdc(IDX_FAST_CNT, 32'hffff, 32'h0);
        wr(IDX_FAST_CTRL, 32'h0);
        repeat (4) @(posedge clock_i);
        rdc(IDX_FAST_STAT, 32'hff, 32'h0);
        // Gap of 1.5 ticks, so one or two steps whatever the phase
        wr(IDX_SLOW_IN, 32'h1);
        apb(1'b0, IDX_SLOW_CNT, 32'h0, 66'h0);
        v = rd;
        repeat (3000) @(posedge clock_i);
        apb(1'b0, IDX_SLOW_CNT, 32'h0, 66'h0);
        w = rd - v;
        check("slow", {31'h0, w == 1 || w == 2}, 32'h1);
        rdc(IDX_SLOW_IN, 32'hffff, 32'h1);
        end_sim();
    end
endmodule : plcm_move_unit_tb_top
`default_nettype wire
